/* File: vdf_defines.vh */
// Constants of the vibration diagnostic and filter block.
`ifndef VDF_DEFINES_VH
`define VDF_DEFINES_VH
// ======================================================================
// Register addresses, byte granular, low byte at the even address.
`define VDF_A_OFS_X 7'h02
`define VDF_A_OFS_Y 7'h04
`define VDF_A_OFS_Z 7'h06
`define VDF_A_CAPT 7'h1c
`define VDF_A_MISC 7'h34
`define VDF_A_AVG 7'h38
`define VDF_A_FLASH 7'h3a
`define VDF_A_DIAG 7'h3c
`define VDF_A_GCMD 7'h3e
`define VDF_A_LOT1 7'h52
`define VDF_A_LOT2 7'h54
`define VDF_A_PROD 7'h56
`define VDF_A_SER 7'h58
// ======================================================================
// Field positions and reset values.
`define VDF_CMD_AUTONULL 0
`define VDF_CMD_SELFTEST 2
`define VDF_CMD_CLRDIAG 4
`define VDF_CMD_FLASHTEST 5
`define VDF_CMD_CAPTURE 11
`define VDF_CAPT_BP 7
`define VDF_MISC_ST 8
`define VDF_RST16 16'h0000
`define VDF_AVG_MAX 4'ha
`define VDF_CAP_LEN 11'h400
`define VDF_AN_LAST 16'hffff
`define VDF_ST_SHIFT 16'h0040
// ======================================================================
// Timing.
`define VDF_CLK_HZ 100000000
`define VDF_BASE_RATE_HZ 72900
`define VDF_TICK_CYC (`VDF_CLK_HZ / `VDF_BASE_RATE_HZ)
`define VDF_SELFTEST_MS 33
// Self-test window of 33 ms at the 100 MHz clock, sized to fit its counter.
`define VDF_SELFTEST_CYC 22'h325aa0
`endif

/* File: vdf_skid.v */
// Two-entry buffer between the filters and the sample output.
`timescale 1ns/100ps
module vdf_skid (
  input wire clk,
  input wire arst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [47:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output reg [47:0] out_data
);
  reg spare_valid;
  reg [47:0] spare_data;
  wire push = in_valid & ~spare_valid;
  assign in_ready = ~spare_valid;
  // ====================================================================
  // Head register drives the port; the spare slot absorbs a stall.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_valid <= 1'b0;
      out_data <= 48'h000000000000;
      spare_valid <= 1'b0;
      spare_data <= 48'h000000000000;
    end else if (~out_valid | out_ready) begin
      if (spare_valid) begin
        out_data <= spare_data;
        out_valid <= 1'b1;
        spare_valid <= 1'b0;
      end else begin
        out_data <= in_data;
        out_valid <= push;
      end
    end else if (push) begin
      spare_data <= in_data;
      spare_valid <= 1'b1;
    end
  end
endmodule

/* File: vdf_axis.v */
// One axis of averaging decimator and optional band-pass stage.
`timescale 1ns/100ps
module vdf_axis (
  input wire clk,
  input wire arst_n,
  input wire in_valid,
  input wire [15:0] in_data,
  input wire [3:0] avg_d,
  input wire bp_en,
  output reg out_valid,
  output reg [15:0] out_data
);
  reg [25:0] acc;
  reg [9:0] cnt;
  reg [3:0] last_d;
  reg signed [17:0] lp1, lp2, hp1, hp2;
  wire [25:0] sum = acc + {{10{in_data[15]}}, in_data};
  wire [25:0] avg = $signed(sum) >>> avg_d;
  wire [9:0] last_cnt = (10'h001 << avg_d) - 10'h001;
  wire signed [17:0] avg18 = {avg[15], avg[15], avg[15:0]};
  wire signed [17:0] n_lp1 = lp1 + ((avg18 - lp1) >>> 2);
  wire signed [17:0] n_lp2 = lp2 + ((n_lp1 - lp2) >>> 2);
  wire signed [17:0] n_hp1 = hp1 + ((n_lp2 - hp1) >>> 4);
  wire signed [17:0] n_hp2 = hp2 + ((n_hp1 - hp2) >>> 4);
  wire signed [17:0] bp = n_lp2 - n_hp2;
  // ====================================================================
  // Coefficients are fixed per output sample, so both corners follow the rate.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc <= 26'h0000000;
      cnt <= 10'h000;
      last_d <= 4'h0;
      lp1 <= 18'h00000;
      lp2 <= 18'h00000;
      hp1 <= 18'h00000;
      hp2 <= 18'h00000;
      out_valid <= 1'b0;
      out_data <= 16'h0000;
    end else begin
      last_d <= avg_d;
      out_valid <= 1'b0;
      if (avg_d != last_d) begin
        acc <= 26'h0000000;
        cnt <= 10'h000;
      end else if (in_valid) begin
        if (cnt == last_cnt) begin
          acc <= 26'h0000000;
          cnt <= 10'h000;
          out_valid <= 1'b1;
          lp1 <= n_lp1;
          lp2 <= n_lp2;
          hp1 <= n_hp1;
          hp2 <= n_hp2;
          out_data <= bp_en ? bp[15:0] : avg[15:0];
        end else begin
          acc <= sum;
          cnt <= cnt + 10'h001;
        end
      end
    end
  end
endmodule

/* File: vdf_core.v */
// Serial register port, status flags, commands and data path of the sensor.
`timescale 1ns/100ps
`include "vdf_defines.vh"
module vdf_core #(
  parameter [21:0] SELFTEST_CYC = `VDF_SELFTEST_CYC,
  parameter [15:0] LOT_IDENT_1_VAL = 16'h1111,
  parameter [15:0] LOT_IDENT_2_VAL = 16'h2222,
  parameter [15:0] PRODUCT_IDENT_VAL = 16'h0a5a,
  parameter [15:0] SERIAL_VAL = 16'h0001
) (
  input wire clk,
  input wire arst_n,
  input wire sclk,
  input wire cs_n,
  input wire mosi,
  output reg miso,
  input wire [15:0] raw_x,
  input wire [15:0] raw_y,
  input wire [15:0] raw_z,
  input wire [15:0] system_data,
  input wire event_mode,
  input wire [15:0] x_alarm_threshold,
  input wire [15:0] y_alarm_threshold,
  input wire [15:0] z_alarm_threshold,
  input wire [15:0] system_alarm_threshold,
  input wire supply_high,
  input wire supply_low,
  input wire selftest_fault,
  output reg selftest_stim,
  output reg flash_check_req,
  input wire flash_check_done,
  input wire flash_check_bad,
  output reg flash_write_req,
  input wire flash_write_done,
  input wire flash_write_bad,
  output reg capture_busy,
  output wire [15:0] out_x,
  output wire [15:0] out_y,
  output wire [15:0] out_z,
  output wire out_valid,
  input wire out_ready
);
  // ====================================================================
  // Byte write into a 16-bit register.
  function [15:0] wr16;
    input [15:0] old;
    input hi;
    input [7:0] b;
    begin
      wr16 = hi ? {b, old[7:0]} : {old[15:8], b};
    end
  endfunction

  reg [15:0] offset_corr_x, offset_corr_y, offset_corr_z;
  reg [15:0] capture_control, misc_control, averaging_count;
  reg [15:0] diagnostic_status, flash_write_count;
  reg sclk_s1, sclk_s2, sclk_s3, cs_s1, cs_s2, cs_s3, mosi_s1, mosi_s2;
  reg sup_hi_s1, sup_hi_s2, sup_lo_s1, sup_lo_s2;
  reg [3:0] bit_cnt;
  reg [15:0] rx, tx, rd_data, rd_mux;
  reg [10:0] tick_cnt;
  reg cap_on;
  reg [10:0] cap_cnt;
  reg st_run, ft_run, an_run;
  reg [21:0] st_cnt;
  reg [15:0] an_cnt;
  reg [31:0] an_sx, an_sy, an_sz;
  reg [15:0] next_diag;
  localparam [31:0] TICK_RELOAD = `VDF_TICK_CYC - 1;

  wire sclk_rise = sclk_s2 & ~sclk_s3;
  wire sclk_fall = ~sclk_s2 & sclk_s3;
  wire frame_start = ~cs_s2 & cs_s3;
  wire frame_end = cs_s2 & ~cs_s3;
  wire word_done = sclk_rise & ~cs_s2 & (bit_cnt == 4'hf);
  wire [15:0] word = {rx[14:0], mosi_s2};
  wire wr_en = word_done & word[15];
  wire [6:0] wr_addr = {word[14:9], 1'b0};
  wire wr_hi = word[8];
  wire [15:0] cmd = (wr_en && wr_addr == `VDF_A_GCMD) ? wr16(16'h0000, wr_hi, word[7:0]) : 16'h0000;
  wire tick = (tick_cnt == 11'h000);
  wire [3:0] avg_d = (averaging_count[3:0] > `VDF_AVG_MAX) ? `VDF_AVG_MAX : averaging_count[3:0];
  wire [15:0] st_add = selftest_stim ? `VDF_ST_SHIFT : 16'h0000;
  wire [15:0] cx = raw_x + offset_corr_x + st_add;
  wire [15:0] cy = raw_y + offset_corr_y + st_add;
  wire [15:0] cz = raw_z + offset_corr_z + st_add;
  wire [47:0] corr_bus = {cz, cy, cx};
  wire [2:0] fv;
  wire [47:0] fbus;
  wire buf_ready;
  wire [2:0] trig_hit = {$signed(raw_z) > $signed(z_alarm_threshold), $signed(raw_y) > $signed(y_alarm_threshold),
    $signed(raw_x) > $signed(x_alarm_threshold)};
  wire ev_start = event_mode & ~cap_on & tick & (|trig_hit);
  wire man_start = cmd[`VDF_CMD_CAPTURE] & ~cap_on;
  wire cap_start = man_start | ev_start;
  wire cap_last = cap_on & fv[0] & buf_ready & (cap_cnt == `VDF_CAP_LEN - 11'h001);
  wire an_last = an_run & tick & (an_cnt == `VDF_AN_LAST);
  wire [31:0] an_nx = an_sx + {{16{raw_x[15]}}, raw_x};
  wire [31:0] an_ny = an_sy + {{16{raw_y[15]}}, raw_y};
  wire [31:0] an_nz = an_sz + {{16{raw_z[15]}}, raw_z};

  // ====================================================================
  // Per-axis filters and output buffer; samples are only taken while the
  // buffer has room, so a stalled reader slows intake instead of losing words.
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : axis
      vdf_axis u_axis (
        .clk(clk),
        .arst_n(arst_n),
        .in_valid(tick & buf_ready),
        .in_data(corr_bus[16*g+15:16*g]),
        .avg_d(avg_d),
        .bp_en(capture_control[`VDF_CAPT_BP]),
        .out_valid(fv[g]),
        .out_data(fbus[16*g+15:16*g])
      );
    end
  endgenerate

  vdf_skid u_skid (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(fv[0]),
    .in_ready(buf_ready),
    .in_data(fbus),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data({out_z, out_y, out_x})
  );

  // ====================================================================
  // Pin synchronisers and serial shift logic.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_s1 <= 1'b1;
      sclk_s2 <= 1'b1;
      sclk_s3 <= 1'b1;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
      sup_hi_s1 <= 1'b0;
      sup_hi_s2 <= 1'b0;
      sup_lo_s1 <= 1'b0;
      sup_lo_s2 <= 1'b0;
      bit_cnt <= 4'h0;
      rx <= 16'h0000;
      tx <= 16'h0000;
      rd_data <= 16'h0000;
      miso <= 1'b0;
    end else begin
      sclk_s1 <= sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      mosi_s1 <= mosi;
      mosi_s2 <= mosi_s1;
      sup_hi_s1 <= supply_high;
      sup_hi_s2 <= sup_hi_s1;
      sup_lo_s1 <= supply_low;
      sup_lo_s2 <= sup_lo_s1;
      if (frame_start) begin
        bit_cnt <= 4'h0;
        miso <= rd_data[15];
        // The first falling edge presents bit 15 again, since mode 3 launches data there.
        tx <= rd_data;
      end else if (sclk_fall && !cs_s2) begin
        miso <= tx[15];
        tx <= {tx[14:0], 1'b0};
      end
      if (sclk_rise && !cs_s2) begin
        rx <= word;
        bit_cnt <= bit_cnt + 4'h1;
      end
      if (word_done && !word[15]) begin
        rd_data <= rd_mux;
      end
    end
  end

  // ====================================================================
  // Read decode; a read only samples, it never clears a flag.
  always @* begin
    case ({word[14:9], 1'b0})
      `VDF_A_OFS_X: rd_mux = offset_corr_x;
      `VDF_A_OFS_Y: rd_mux = offset_corr_y;
      `VDF_A_OFS_Z: rd_mux = offset_corr_z;
      `VDF_A_CAPT: rd_mux = capture_control;
      `VDF_A_MISC: rd_mux = misc_control;
      `VDF_A_AVG: rd_mux = averaging_count;
      `VDF_A_FLASH: rd_mux = flash_write_count;
      `VDF_A_DIAG: rd_mux = diagnostic_status;
      `VDF_A_LOT1: rd_mux = LOT_IDENT_1_VAL;
      `VDF_A_LOT2: rd_mux = LOT_IDENT_2_VAL;
      `VDF_A_PROD: rd_mux = PRODUCT_IDENT_VAL;
      `VDF_A_SER: rd_mux = SERIAL_VAL;
      default: rd_mux = 16'h0000;
    endcase
  end

  // ====================================================================
  // Sticky status: a set in the same cycle as a clear wins.
  always @* begin
    next_diag = (cmd[`VDF_CMD_CLRDIAG] | cap_start) ? 16'h0000 : diagnostic_status;
    if (ev_start)
      next_diag[14:12] = next_diag[14:12] | trig_hit;
    if (cap_on && fv[0] && buf_ready) begin
      next_diag[8] = next_diag[8] | ($signed(fbus[15:0]) > $signed(x_alarm_threshold));
      next_diag[9] = next_diag[9] | ($signed(fbus[31:16]) > $signed(y_alarm_threshold));
      next_diag[10] = next_diag[10] | ($signed(fbus[47:32]) > $signed(z_alarm_threshold));
    end
    if (cap_on && tick)
      next_diag[11] = next_diag[11] | ($signed(system_data) > $signed(system_alarm_threshold));
    if (cap_last)
      next_diag[7] = 1'b1;
    if (ft_run && flash_check_done)
      next_diag[6] = next_diag[6] | flash_check_bad;
    if (st_run && st_cnt == SELFTEST_CYC - 22'h000001)
      next_diag[5] = next_diag[5] | selftest_fault;
    if (frame_start && cap_on)
      next_diag[4] = 1'b1;
    if (frame_end && bit_cnt != 4'h0)
      next_diag[3] = 1'b1;
    if (flash_write_done)
      next_diag[2] = next_diag[2] | flash_write_bad;
    next_diag[1] = next_diag[1] | sup_hi_s2;
    next_diag[0] = next_diag[0] | sup_lo_s2;
    next_diag[15] = 1'b0;
  end

  // ====================================================================
  // Registers, commands, capture, self-test, flash and autonull.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      offset_corr_x <= `VDF_RST16;
      offset_corr_y <= `VDF_RST16;
      offset_corr_z <= `VDF_RST16;
      capture_control <= `VDF_RST16;
      misc_control <= `VDF_RST16;
      averaging_count <= `VDF_RST16;
      diagnostic_status <= `VDF_RST16;
      flash_write_count <= `VDF_RST16;
      tick_cnt <= 11'h000;
      cap_on <= 1'b0;
      cap_cnt <= 11'h000;
      capture_busy <= 1'b0;
      st_run <= 1'b0;
      st_cnt <= 22'h000000;
      selftest_stim <= 1'b0;
      ft_run <= 1'b0;
      flash_check_req <= 1'b0;
      flash_write_req <= 1'b0;
      an_run <= 1'b0;
      an_cnt <= 16'h0000;
      an_sx <= 32'h00000000;
      an_sy <= 32'h00000000;
      an_sz <= 32'h00000000;
    end else begin
      diagnostic_status <= next_diag;
      tick_cnt <= tick ? TICK_RELOAD[10:0] : tick_cnt - 11'h001;
      flash_check_req <= 1'b0;
      flash_write_req <= 1'b0;
      if (wr_en) begin
        case (wr_addr)
          `VDF_A_OFS_X: offset_corr_x <= wr16(offset_corr_x, wr_hi, word[7:0]);
          `VDF_A_OFS_Y: offset_corr_y <= wr16(offset_corr_y, wr_hi, word[7:0]);
          `VDF_A_OFS_Z: offset_corr_z <= wr16(offset_corr_z, wr_hi, word[7:0]);
          `VDF_A_CAPT: capture_control <= wr16(capture_control, wr_hi, word[7:0]);
          `VDF_A_MISC: misc_control <= wr16(misc_control, wr_hi, word[7:0]);
          `VDF_A_AVG: averaging_count <= wr16(averaging_count, wr_hi, word[7:0]);
          default: ;
        endcase
      end
      if (flash_write_done)
        flash_write_count <= flash_write_count + 16'h0001;
      // Capture: 1024 buffered samples end it, a second start command stops it.
      if (cap_start) begin
        cap_on <= 1'b1;
        cap_cnt <= 11'h000;
      end else if (cap_last || (cmd[`VDF_CMD_CAPTURE] && cap_on)) begin
        cap_on <= 1'b0;
      end else if (cap_on && fv[0] && buf_ready) begin
        cap_cnt <= cap_cnt + 11'h001;
      end
      capture_busy <= cap_on | st_run | ft_run | an_run;
      selftest_stim <= misc_control[`VDF_MISC_ST] | st_run;
      if (cmd[`VDF_CMD_SELFTEST] && !st_run) begin
        st_run <= 1'b1;
        st_cnt <= 22'h000000;
      end else if (st_run) begin
        st_cnt <= st_cnt + 22'h000001;
        if (st_cnt == SELFTEST_CYC - 22'h000001)
          st_run <= 1'b0;
      end
      if (cmd[`VDF_CMD_FLASHTEST] && !ft_run) begin
        ft_run <= 1'b1;
        flash_check_req <= 1'b1;
      end else if (flash_check_done) begin
        ft_run <= 1'b0;
      end
      // Autonull sums raw samples, so the old correction does not bias it.
      if (cmd[`VDF_CMD_AUTONULL] && !an_run) begin
        an_run <= 1'b1;
        an_cnt <= 16'h0000;
        an_sx <= 32'h00000000;
        an_sy <= 32'h00000000;
        an_sz <= 32'h00000000;
      end else if (an_last) begin
        an_run <= 1'b0;
        offset_corr_x <= 16'h0000 - an_nx[31:16];
        offset_corr_y <= 16'h0000 - an_ny[31:16];
        offset_corr_z <= 16'h0000 - an_nz[31:16];
        flash_write_req <= 1'b1;
      end else if (an_run && tick) begin
        an_cnt <= an_cnt + 16'h0001;
        an_sx <= an_nx;
        an_sy <= an_ny;
        an_sz <= an_nz;
      end
    end
  end
endmodule

/* File: vdf_core_sva.sv */
// Assertion checker for the ports of the vibration core.
`timescale 1ns/100ps
module vdf_core_chk (
  input wire clk,
  input wire arst_n,
  input wire miso,
  input wire capture_busy,
  input wire selftest_stim,
  input wire flash_check_req,
  input wire flash_check_done,
  input wire flash_write_req,
  input wire out_valid,
  input wire out_ready,
  input wire [15:0] out_x,
  input wire [15:0] out_y,
  input wire [15:0] out_z
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ======================================================================
  // Helper: cycles since the last rise of out_valid.
  // The count saturates so that a long idle spell never wraps into a false short gap.
  reg pv;
  reg [11:0] gap;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pv <= 1'b0;
      gap <= 12'hfff;
    end else begin
      pv <= out_valid;
      gap <= (out_valid && !pv) ? 12'h000 : ((gap == 12'hfff) ? gap : gap + 12'h001);
    end
  end
  // ======================================================================
  // Properties.
  property p_valid_hold;
    out_valid && !out_ready |=> out_valid;
  endproperty
  a_valid_hold: assert property (p_valid_hold) else $error("sample dropped while stalled");
  property p_data_hold;
    out_valid && !out_ready |=> $stable({out_x, out_y, out_z});
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("sample changed while stalled");
  property p_gap;
    out_valid && !pv |-> gap >= 12'h55a;
  endproperty
  a_gap: assert property (p_gap) else $error("samples closer than one tick");
  property p_chk_pulse;
    flash_check_req |=> !flash_check_req;
  endproperty
  a_chk_pulse: assert property (p_chk_pulse) else $error("flash check request too long");
  property p_wr_pulse;
    flash_write_req |=> !flash_write_req;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("flash write request too long");
  property p_chk_busy;
    flash_check_req |=> capture_busy;
  endproperty
  a_chk_busy: assert property (p_chk_busy) else $error("busy not shown during flash check");
  property p_chk_once;
    flash_check_req ##1 (!flash_check_done) [*2] |-> !flash_check_req;
  endproperty
  a_chk_once: assert property (p_chk_once) else $error("flash check restarted while running");
  property p_rst_quiet;
    $rose(arst_n) |-> !out_valid && !capture_busy && !flash_check_req && !flash_write_req && !selftest_stim && !miso;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not idle after reset");
  c_flash: cover property (flash_check_req);
  c_stall: cover property (out_valid && !out_ready);
  c_stim: cover property (selftest_stim);
endmodule
bind vdf_core vdf_core_chk u_chk (.clk(clk), .arst_n(arst_n), .miso(miso), .capture_busy(capture_busy),
  .selftest_stim(selftest_stim), .flash_check_req(flash_check_req), .flash_check_done(flash_check_done),
  .flash_write_req(flash_write_req), .out_valid(out_valid), .out_ready(out_ready), .out_x(out_x),
  .out_y(out_y), .out_z(out_z));

/* File: vdf_host.sv */
// Host model: serial master of the sensor's register port.
`timescale 1ns/100ps
module vdf_host (
  input wire clk,
  output reg sclk,
  output reg cs_n,
  output reg mosi,
  input wire miso
);
  localparam int HALF = 8;
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // Mode 3: data moves on the falling edge, both sides sample on the rising edge.
  // The serial clock stands high between frames; half period of 8 clk gives 80 ns, a 160 ns period.
  task automatic xfer(input logic [15:0] w, input int nb, output logic [15:0] r);
    int i;
    r = 16'h0000;
    @(negedge clk);
    cs_n = 1'b0;
    repeat (HALF) @(negedge clk);
    for (i = 0; i < nb; i++) begin
      sclk = 1'b0;
      mosi = w[15 - i];
      repeat (HALF) @(negedge clk);
      sclk = 1'b1;
      r = {r[14:0], miso};
      repeat (HALF) @(negedge clk);
    end
    repeat (HALF) @(negedge clk);
    cs_n = 1'b1;
    // A released data line must not keep its last bit for the device to lean on.
    mosi = ~mosi;
    repeat (2 * HALF) @(negedge clk);
  endtask
endmodule

/* File: vdf_core_tb.sv */
// Self-checking bench for the vibration core.
`timescale 1ns/100ps
`include "vdf_defines.vh"
module vdf_core_tb;
  localparam int TK = `VDF_TICK_CYC;
  reg clk = 1'b0;
  reg arst_n = 1'b0;
  wire sclk, cs_n, mosi, miso, st_stim, ck_req, wr_req, busy, ov;
  wire [15:0] ox, oy, oz;
  reg [15:0] rx = 16'h0, ry = 16'h0, rz = 16'h0, sd = 16'h0, thx = 16'h7fff, r, v;
  reg sup_hi = 1'b0, sup_lo = 1'b0, st_bad = 1'b0, ck_done = 1'b0, ck_bad = 1'b0;
  reg wr_done = 1'b0, wr_bad = 1'b0, rdy = 1'b1, en = 1'b0, ev = 1'b0;
  reg [47:0] e48;
  reg [47:0] exp_q[$];
  reg [62:0] tbl = {7'h02, 7'h04, 7'h06, 7'h1c, 7'h34, 7'h38, 7'h3a, 7'h3c, 7'h3e};
  integer seed = 32'he16dc9a3;
  integer fail_count = 0, n_tests = 0, cyc = 0, i;
  initial forever #5 clk = ~clk;
  vdf_core #(.SELFTEST_CYC(22'd200)) dut (.clk(clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .miso(miso), .raw_x(rx), .raw_y(ry), .raw_z(rz), .system_data(sd), .event_mode(ev),
    .x_alarm_threshold(thx), .y_alarm_threshold(thx), .z_alarm_threshold(thx),
    .system_alarm_threshold(thx), .supply_high(sup_hi), .supply_low(sup_lo), .selftest_fault(st_bad),
    .selftest_stim(st_stim), .flash_check_req(ck_req), .flash_check_done(ck_done), .flash_check_bad(ck_bad),
    .flash_write_req(wr_req), .flash_write_done(wr_done), .flash_write_bad(wr_bad), .capture_busy(busy),
    .out_x(ox), .out_y(oy), .out_z(oz), .out_valid(ov), .out_ready(rdy));
  vdf_host u_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  // ======================================================================
  // Checking and bus tasks.
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] t;
    u_host.xfer({1'b1, a, d}, 16, t);
  endtask
  // The answer comes in the following frame, so the first frame's reply is thrown away.
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    logic [15:0] t;
    u_host.xfer({1'b0, a, 8'h00}, 16, t);
    u_host.xfer(16'h0000, 16, d);
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ======================================================================
  // Monitor, flash responder and watchdog.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      fail_count++;
      tally_and_finish;
    end
    if (en && ov && rdy && exp_q.size() > 0) begin
      e48 = exp_q.pop_front();
      chk("out_x", e48[47:32], ox);
      chk("out_y", e48[31:16], oy);
      chk("out_z", e48[15:0], oz);
    end
  end
  initial forever begin
    @(posedge clk);
    if (ck_req) begin
      repeat (20) @(negedge clk);
      ck_done = 1'b1;
      ck_bad = 1'b1;
      @(negedge clk);
      ck_done = 1'b0;
    end
  end
  // ======================================================================
  // Main sequence.
  initial begin
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    for (i = 0; i < 9; i++) begin
      rd(tbl[i * 7 +: 7], r);
      chk("reset value", 16'h0000, r);
    end
    $display("test reset values done");
    v = $random(seed);
    wr(7'h02, v[7:0]);
    wr(7'h03, v[15:8]);
    rd(7'h02, r);
    chk("offset_corr_x", v, r);
    wr(7'h10, 8'hff);
    rd(7'h10, r);
    chk("unmapped", 16'h0000, r);
    $display("test registers done");
    sup_hi = 1'b1;
    repeat (4) @(negedge clk);
    sup_hi = 1'b0;
    sup_lo = 1'b1;
    repeat (4) @(negedge clk);
    sup_lo = 1'b0;
    rd(7'h3c, r);
    chk("status", 16'h0003, r);
    rd(7'h3c, r);
    chk("status", 16'h0003, r);
    wr(7'h3e, 8'h10);
    rd(7'h3c, r);
    chk("status", 16'h0000, r);
    u_host.xfer(16'h0000, 8, r);
    rd(7'h3c, r);
    chk("status", 16'h0008, r);
    wr(7'h3e, 8'h10);
    $display("test flags done");
    st_bad = 1'b1;
    wr(7'h3e, 8'h04);
    repeat (4) @(negedge clk);
    chk("stim", 16'h0001, {15'h0, st_stim});
    repeat (260) @(negedge clk);
    chk("busy", 16'h0000, {15'h0, busy});
    rd(7'h3c, r);
    chk("status", 16'h0020, r);
    wr(7'h3e, 8'h10);
    wr(7'h35, 8'h01);
    repeat (4) @(negedge clk);
    chk("stim", 16'h0001, {15'h0, st_stim});
    rd(7'h34, r);
    chk("misc_control", 16'h0100, r);
    wr(7'h35, 8'h00);
    repeat (4) @(negedge clk);
    chk("stim", 16'h0000, {15'h0, st_stim});
    wr(7'h3e, 8'h20);
    repeat (40) @(negedge clk);
    chk("busy", 16'h0000, {15'h0, busy});
    wr_bad = 1'b1;
    wr_done = 1'b1;
    @(negedge clk);
    wr_done = 1'b0;
    rd(7'h3a, r);
    chk("flash_write_count", 16'h0001, r);
    rd(7'h3c, r);
    chk("status", 16'h0044, r);
    $display("test self-test and flash done");
    rx = ($random(seed) & 16'h0fff) | 16'h0001;
    ry = ($random(seed) & 16'h0fff) | 16'h0001;
    rz = ($random(seed) & 16'h0fff) | 16'h0001;
    sd = ($random(seed) & 16'h0fff) | 16'h0001;
    v = $random(seed) & 16'h00ff;
    wr(7'h02, v[7:0]);
    wr(7'h03, 8'h00);
    wr(7'h38, 8'h01);
    // Flush filter history built up from the old inputs before checking.
    repeat (10 * TK) @(negedge clk);
    en = 1'b1;
    for (i = 0; i < 4; i++) exp_q.push_back({rx + v, ry, rz});
    rdy = 1'b0;
    repeat (6 * TK) @(negedge clk);
    i = 0;
    while (exp_q.size() > 0 && i < 30000) begin
      rdy = $random(seed);
      @(negedge clk);
      i++;
    end
    rdy = 1'b1;
    chk("drained", 16'h0000, exp_q.size() > 0 ? 16'h0001 : 16'h0000);
    en = 1'b0;
    repeat (2 * TK) @(negedge clk);
    i = 0;
    while (!ov && i < 6000) begin
      @(negedge clk);
      i++;
    end
    @(negedge clk);
    i = 1;
    while (!ov && i < 6000) begin
      @(negedge clk);
      i++;
    end
    chk("sample period", 2 * TK, i);
    $display("test stream done");
    thx = 16'h0000;
    u_host.xfer(16'h0000, 8, r);
    wr(7'h3f, 8'h08);
    repeat (10 * TK) @(negedge clk);
    chk("busy", 16'h0001, {15'h0, busy});
    rd(7'h3c, r);
    chk("status", 16'h0f10, r);
    wr(7'h3f, 8'h08);
    $display("test capture done");
    ev = 1'b1;
    repeat (3 * TK) @(negedge clk);
    rd(7'h3c, r);
    chk("status", 16'h7f10, r);
    ev = 1'b0;
    wr(7'h3f, 8'h08);
    $display("test event capture done");
    tally_and_finish;
  end
endmodule
